/* File: src/osc_and_freq_locked_loop_control_regs.sv */
// Purpose: Oscillator and frequency-locked loop control registers
// Assumes: Bus strobes and ticks are synchronous one-cycle pulses on clk
// Notes: por_n resets only the slow oscillator register; rst_n the rest
// Functional notes
// - Main mode bit picks external clock or crystal
// - Protected registers take writes only after unlock
// - Key plus offset, then very next access
// - Slow oscillator register reset only by power-on
// - Start-up code selects RC cycle wait
// - Slow mode codes: external, crystal, high current
// - Enable bit gates the 1 kHz output
// - Enable bit gates the 32 kHz output
// - Pin select picks default or alternate pins
// - Slow oscillator enable turns it on
// - Coarse value writable only in open loop
// - Fine value writable only in open loop
// - Dither bit dithers fine LSB input
// - Loop mode bit: open or closed
// - Loop enable bit starts and stops loop
// - Multiplier holds integer and fraction halves
// - Multiplier writes ignored in open loop
`timescale 1ns/1ps
module osc_and_freq_locked_loop_control_regs #(
  parameter logic [19:0] START_TABLE [8] = osc_freq_locked_loop_pkg::START_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [9:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  input wire logic rc_tick,
  input wire logic ref_tick,
  input wire logic vco_tick,
  output logic main_osc_enable,
  output logic main_osc_crystal,
  output logic main_out_pin_gpio,
  output logic slow_osc_enable,
  output logic slow_osc_crystal,
  output logic slow_osc_high_current,
  output logic slow_out_pin_gpio,
  output logic alt_pin_select,
  output logic slow_osc_ready,
  output logic one_khz_out_enable,
  output logic slow_clk_out_enable,
  output logic loop_enable,
  output logic loop_closed,
  output logic [7:0] vco_coarse,
  output logic [8:0] vco_fine
);
  import osc_freq_locked_loop_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] main_reg; // Main oscillator control
  logic [31:0] slow_reg; // Slow oscillator control
  logic [2:0] conf_ctrl_reg; // Dither, mode, enable
  logic [7:0] coarse_reg; // Coarse calibration
  logic [8:0] fine_reg; // Fine calibration
  logic [31:0] mul_reg; // Integer and fraction ratio
  logic armed_reg; // Unlock pending
  logic [9:0] armed_addr_reg; // Offset that was unlocked
  logic [31:0] rdata_reg; // Read data
  logic [START_W-1:0] start_cnt_reg; // RC cycles since enable
  logic ready_reg; // Slow oscillator ready
  logic [15:0] vco_cnt_reg; // VCO ticks in current ref period
  logic [15:0] frac_acc_reg; // Fraction accumulator
  logic carry_reg; // Dither carry
  logic last_up_reg; // Last tuning direction
  loop_state_e state_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic wr; // Bus write strobe
  logic unlock_wr; // Valid key write
  logic unlocked; // This write was unlocked
  logic main_wr;
  logic slow_wr;
  logic conf_wr;
  logic mul_wr;
  logic closed; // Current loop mode
  logic [15:0] ratio_integer;
  logic [15:0] ratio_fraction;
  logic [16:0] frac_sum;
  logic [START_W-1:0] start_target;
  logic too_slow;
  logic too_fast;

  assign wr = bus_valid && bus_write;
  // Key in top byte and offset low bits arm the next access
  assign unlock_wr = wr && bus_addr == UNLOCK_OFS
    && bus_wdata[KEY_LSB+:8] == UNLOCK_KEY;
  // Protected write must hit the armed offset
  assign unlocked = armed_reg && armed_addr_reg == bus_addr;
  assign main_wr = wr && bus_addr == MAIN_OSC_OFS && unlocked;
  assign slow_wr = wr && bus_addr == SLOW_OSC_OFS;
  assign conf_wr = wr && bus_addr == CONF_OFS && unlocked;
  assign closed = conf_ctrl_reg[CONF_MODE_BIT];
  // Multiplier only accepts writes in closed loop
  assign mul_wr = wr && bus_addr == MUL_OFS && closed;
  // Integer in upper half, fraction in lower half
  assign ratio_integer = mul_reg[31:16];
  assign ratio_fraction = mul_reg[15:0];
  assign frac_sum = {1'b0, frac_acc_reg} + {1'b0, ratio_fraction};
  assign start_target = START_TABLE[slow_reg[SLOW_START_LSB+:3]];
  assign too_slow = vco_cnt_reg < ratio_integer;
  assign too_fast = vco_cnt_reg > ratio_integer;

  // ----------------------------------------
  // Unlock tracking
  // ----------------------------------------
  // Any access consumes the unlock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
      armed_addr_reg <= 10'h000;
    end else if (bus_valid) begin
      armed_reg <= unlock_wr;
      armed_addr_reg <= bus_wdata[9:0];
    end
  end

  // ----------------------------------------
  // Main oscillator register
  // ----------------------------------------
  // Write only when unlocked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_reg <= MAIN_RESET;
    end else if (main_wr) begin
      main_reg <= bus_wdata & MAIN_MASK;
    end
  end

  // ----------------------------------------
  // Slow oscillator register
  // ----------------------------------------
  // Power-on only reset; reserved bit stored as zero
  always_ff @(posedge clk) begin
    if (!por_n) begin
      slow_reg <= SLOW_RESET;
    end else if (slow_wr) begin
      slow_reg <= bus_wdata & SLOW_MASK;
    end
  end

  // ----------------------------------------
  // Start-up counter
  // ----------------------------------------
  // Count RC cycles after enable until the code's wait
  always_ff @(posedge clk) begin
    if (!rst_n || !slow_reg[SLOW_EN_BIT]) begin
      start_cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else if (start_cnt_reg >= start_target) begin
      ready_reg <= 1'b1;
    end else if (rc_tick) begin
      start_cnt_reg <= start_cnt_reg + 20'h00001;
    end
  end

  // ----------------------------------------
  // Loop configuration control bits
  // ----------------------------------------
  // Enable, mode and dither, unlocked writes only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conf_ctrl_reg <= CONF_RESET[2:0];
    end else if (conf_wr) begin
      conf_ctrl_reg <= bus_wdata[2:0];
    end
  end

  // ----------------------------------------
  // Multiplier register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mul_reg <= MUL_RESET;
    end else if (mul_wr) begin
      mul_reg <= bus_wdata;
    end
  end

  // ----------------------------------------
  // VCO period measurement
  // ----------------------------------------
  // Counts VCO ticks between reference ticks
  always_ff @(posedge clk) begin
    if (!rst_n || !loop_enable) begin
      vco_cnt_reg <= 16'h0000;
    end else if (ref_tick) begin
      vco_cnt_reg <= {15'h0000, vco_tick};
    end else if (vco_tick && vco_cnt_reg != 16'hFFFF) begin
      vco_cnt_reg <= vco_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Fraction dither accumulator
  // ----------------------------------------
  // Carry adds one fine LSB to spread the fraction
  always_ff @(posedge clk) begin
    if (!rst_n || !conf_ctrl_reg[CONF_DITHER_BIT]) begin
      frac_acc_reg <= 16'h0000;
      carry_reg <= 1'b0;
    end else if (ref_tick) begin
      frac_acc_reg <= frac_sum[15:0];
      carry_reg <= frac_sum[16];
    end
  end

  // ----------------------------------------
  // Tuning state
  // ----------------------------------------
  // Coarse first, then fine once the error changes sign or reaches zero
  always_ff @(posedge clk) begin
    if (!rst_n || !loop_enable || !closed) begin
      state_reg <= LOOP_IDLE;
    end else if (ref_tick) begin
      case (state_reg)
        LOOP_IDLE: begin
          state_reg <= LOOP_COARSE;
        end
        LOOP_COARSE: begin
          if (!too_slow && !too_fast) begin
            state_reg <= LOOP_FINE;
          end else if (too_slow != last_up_reg) begin
            state_reg <= LOOP_FINE; // Overshoot seen
          end
        end
        default: begin
          state_reg <= LOOP_FINE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Calibration values
  // ----------------------------------------
  // Software owns them in open loop, hardware in closed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coarse_reg <= CONF_RESET[COARSE_LSB+:8];
      fine_reg <= CONF_RESET[FINE_LSB+:9];
      last_up_reg <= 1'b0;
    end else if (!closed) begin
      if (conf_wr) begin
        coarse_reg <= bus_wdata[COARSE_LSB+:8];
        fine_reg <= bus_wdata[FINE_LSB+:9];
      end
    end else if (loop_enable && ref_tick) begin
      // Idle tick seeds the direction, so the first coarse step is no overshoot
      last_up_reg <= too_slow;
      if (state_reg == LOOP_COARSE) begin
        // Coarse steps, saturating
        if (too_slow && coarse_reg != 8'hFF) begin
          coarse_reg <= coarse_reg + 8'h01;
        end else if (too_fast && coarse_reg != 8'h00) begin
          coarse_reg <= coarse_reg - 8'h01;
        end
      end else if (state_reg == LOOP_FINE) begin
        // Fine steps, saturating
        if (too_slow && fine_reg != 9'h1FF) begin
          fine_reg <= fine_reg + 9'h001;
        end else if (too_fast && fine_reg != 9'h000) begin
          fine_reg <= fine_reg - 9'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unlock and unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
    end else if (bus_valid && !bus_write) begin
      if (bus_addr == MAIN_OSC_OFS) begin
        rdata_reg <= main_reg;
      end else if (bus_addr == SLOW_OSC_OFS) begin
        rdata_reg <= slow_reg;
      end else if (bus_addr == CONF_OFS) begin
        rdata_reg <= {coarse_reg, 7'h00, fine_reg, 5'h00, conf_ctrl_reg};
      end else if (bus_addr == MUL_OFS) begin
        rdata_reg <= mul_reg;
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata = rdata_reg;
  assign main_osc_enable = main_reg[16];
  assign main_osc_crystal = main_reg[MAIN_MODE_BIT];
  assign main_out_pin_gpio = !main_reg[MAIN_MODE_BIT];
  assign slow_osc_enable = slow_reg[SLOW_EN_BIT];
  assign slow_osc_crystal = slow_reg[SLOW_MODE_LSB+:3] == SLOW_MODE_XTAL
    || slow_reg[SLOW_MODE_LSB+:3] == SLOW_MODE_XTAL_HI;
  assign slow_osc_high_current = slow_reg[SLOW_MODE_LSB+:3] == SLOW_MODE_XTAL_HI;
  assign slow_out_pin_gpio = slow_reg[SLOW_MODE_LSB+:3] == SLOW_MODE_EXT;
  assign alt_pin_select = slow_reg[SLOW_PIN_BIT];
  assign slow_osc_ready = ready_reg;
  assign one_khz_out_enable = slow_reg[SLOW_1K_BIT];
  assign slow_clk_out_enable = slow_reg[SLOW_32K_BIT];
  assign loop_enable = conf_ctrl_reg[CONF_EN_BIT];
  assign loop_closed = closed;
  assign vco_coarse = coarse_reg;
  // Dither carry lifts the fine input by one LSB
  assign vco_fine = (carry_reg && fine_reg != 9'h1FF) ? fine_reg + 9'h001 : fine_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  locked_conf_a: assert property (
    wr && bus_addr == CONF_OFS && !unlocked |=> $stable(conf_ctrl_reg))
    else $error("Locked config write took effect");
  locked_main_a: assert property (
    wr && bus_addr == MAIN_OSC_OFS && !armed_reg |=> $stable(main_reg))
    else $error("Locked main write took effect");
  unlock_next_a: assert property (
    unlock_wr ##1 bus_valid && !unlock_wr |=> !armed_reg)
    else $error("Unlock outlived next access");
  por_keep_a: assert property (@(posedge clk) disable iff (!por_n)
    !rst_n && !slow_wr |=> $stable(slow_reg))
    else $error("Slow register lost on system reset");
  ready_wait_a: assert property (
    $rose(ready_reg) |-> start_cnt_reg >= $past(start_target) && slow_osc_enable)
    else $error("Ready before start-up wait");
  ready_drop_a: assert property (
    !slow_osc_enable |=> !slow_osc_ready)
    else $error("Ready while disabled");
  out_gate_a: assert property (
    slow_wr && bus_wdata[SLOW_32K_BIT] && por_n |=> slow_clk_out_enable)
    else $error("32 kHz enable not applied");
  mul_open_a: assert property (
    wr && bus_addr == MUL_OFS && !closed |=> $stable(mul_reg))
    else $error("Multiplier written in open loop");
  coarse_hold_a: assert property (
    closed && !ref_tick |=> $stable(coarse_reg) && $stable(fine_reg))
    else $error("Calibration changed without reference tick");
  dither_off_a: assert property (
    !conf_ctrl_reg[CONF_DITHER_BIT] ##1 1'b1 |-> vco_fine == fine_reg)
    else $error("Fine input dithered while off");

  unlocked_conf_c: cover property (conf_wr);
  ready_rise_c: cover property ($rose(slow_osc_ready));
  coarse_to_fine_c: cover property (state_reg == LOOP_COARSE ##1 state_reg == LOOP_FINE);
  mul_taken_c: cover property (mul_wr);
endmodule

/* File: inc/osc_freq_locked_loop_pkg.sv */
// Purpose: Shared offsets, fields, resets and counts for the clock-source control block
// Assumes: 32-bit peripheral bus words, 10-bit byte offsets
// Notes: Oscillator start-up counts are in internal RC clock cycles
package osc_freq_locked_loop_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [9:0] UNLOCK_OFS = 10'h018;
  localparam logic [9:0] MAIN_OSC_OFS = 10'h024;
  localparam logic [9:0] SLOW_OSC_OFS = 10'h02C;
  localparam logic [9:0] CONF_OFS = 10'h034;
  localparam logic [9:0] MUL_OFS = 10'h038;
  // ----------------------------------------
  // Unlock word fields
  // ----------------------------------------
  localparam logic [7:0] UNLOCK_KEY = 8'hAA;
  localparam int KEY_LSB = 24;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MAIN_MODE_BIT = 0;
  localparam logic [31:0] MAIN_MASK = 32'h00010F0F;
  localparam int SLOW_EN_BIT = 0;
  localparam int SLOW_PIN_BIT = 1;
  localparam int SLOW_32K_BIT = 2;
  localparam int SLOW_1K_BIT = 3;
  localparam int SLOW_MODE_LSB = 8;
  localparam int SLOW_START_LSB = 16;
  localparam logic [31:0] SLOW_MASK = 32'h0007070F;
  localparam int CONF_EN_BIT = 0;
  localparam int CONF_MODE_BIT = 1;
  localparam int CONF_DITHER_BIT = 2;
  localparam int FINE_LSB = 8;
  localparam int COARSE_LSB = 24;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] MAIN_RESET = 32'h00000000;
  localparam logic [31:0] SLOW_RESET = 32'h00000004;
  localparam logic [31:0] CONF_RESET = 32'h00000000;
  localparam logic [31:0] MUL_RESET = 32'h00000000;
  // ----------------------------------------
  // Slow oscillator mode codes
  // ----------------------------------------
  localparam logic [2:0] SLOW_MODE_EXT = 3'h0;
  localparam logic [2:0] SLOW_MODE_XTAL = 3'h1;
  localparam logic [2:0] SLOW_MODE_XTAL_HI = 3'h4;
  // ----------------------------------------
  // Start-up counts per code, RC cycles
  // ----------------------------------------
  localparam int START_W = 20;
  localparam logic [START_W-1:0] START_CYC [8] = '{
    20'h00000, 20'h00080, 20'h02000, 20'h04000,
    20'h10000, 20'h20000, 20'h40000, 20'h80000};
  // ----------------------------------------
  // Loop tuning states
  // ----------------------------------------
  typedef enum logic [2:0] {
    LOOP_IDLE = 3'b001,
    LOOP_COARSE = 3'b010,
    LOOP_FINE = 3'b100
  } loop_state_e;
endpackage

/* File: bench/clock_source_model.sv */
// Purpose: Pin-side clock sources feeding the oscillator control block
// Assumes: Every tick is a one-cycle pulse on clk, launched 1 ns after the edge
// Notes: VCO rate is coarse/256 per clk, so ticks per reference period equal coarse
`timescale 1ns/1ps
module clock_source_model #(
  parameter int RC_DIV = 4,
  parameter int REF_DIV = 256
) (
  input wire logic clk,
  input wire logic [7:0] vco_coarse,
  output logic rc_tick,
  output logic ref_tick,
  output logic vco_tick
);
  // ----------------------------------------
  // Dividers and phase accumulator
  // ----------------------------------------
  int rc_cnt = 0; // Internal RC divider
  int ref_cnt = 0; // Reference divider
  logic [8:0] phase = 9'h000; // Carry bit marks a VCO tick
  // Ticks start low so nothing is counted before the first period
  initial begin
    rc_tick = 1'b0;
    ref_tick = 1'b0;
    vco_tick = 1'b0;
  end
  // Free-running RC ticks pace the start-up wait
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == RC_DIV - 1) ? 0 : rc_cnt + 1;
    rc_tick <= #1 (rc_cnt == RC_DIV - 1);
  end
  // Reference and a VCO whose rate follows the coarse value
  always @(posedge clk) begin
    ref_cnt <= (ref_cnt == REF_DIV - 1) ? 0 : ref_cnt + 1;
    ref_tick <= #1 (ref_cnt == REF_DIV - 1);
    phase <= {1'b0, phase[7:0]} + {1'b0, vco_coarse};
    vco_tick <= #1 phase[8];
  end
endmodule

/* File: bench/osc_and_freq_locked_loop_control_regs_tb_top.sv */
// Purpose: Self-checking bench for the oscillator and loop control registers
// Assumes: One access strobe, then one idle cycle, per bus task
// Notes: Start-up table is shortened so every code finishes quickly
`timescale 1ns/1ps
module osc_and_freq_locked_loop_control_regs_tb_top;
  import osc_freq_locked_loop_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [19:0] ST [8] = '{20'h00000, 20'h00002, 20'h00004, 20'h00008,
    20'h00010, 20'h00020, 20'h00040, 20'h00080}; // Short start-up counts
  localparam logic [2:0] MODES [3] = '{3'h0, 3'h1, 3'h4}; // Slow mode codes
  localparam logic [2:0] PINS [3] = '{3'b100, 3'b010, 3'b011}; // gpio, xtal, high
  localparam logic [3:0] LOWS [3] = '{4'hB, 4'h4, 4'h3}; // Low control bits
  logic clk = 1'b0;
  logic rst_n, por_n, bus_valid, bus_write;
  logic [9:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata, q, w;
  logic rc_tick, ref_tick, vco_tick;
  logic main_osc_enable, main_osc_crystal, main_out_pin_gpio;
  logic slow_osc_enable, slow_osc_crystal, slow_osc_high_current, slow_out_pin_gpio;
  logic alt_pin_select, slow_osc_ready, one_khz_out_enable, slow_clk_out_enable;
  logic loop_enable, loop_closed;
  logic [7:0] vco_coarse;
  logic [8:0] vco_fine;
  logic [31:0] bad [3];
  int error_cnt = 0; // Mismatches
  int checked = 0; // Comparisons
  int cyc = 0; // Cycle count for the timeout
  int ticks = 0; // RC ticks seen while waiting for ready
  int i, n, hi, lo;
  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  always #2 clk = ~clk;
  osc_and_freq_locked_loop_control_regs #(.START_TABLE(ST)) i_dut (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .bus_valid(bus_valid),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .rc_tick(rc_tick), .ref_tick(ref_tick),
    .vco_tick(vco_tick), .main_osc_enable(main_osc_enable),
    .main_osc_crystal(main_osc_crystal), .main_out_pin_gpio(main_out_pin_gpio),
    .slow_osc_enable(slow_osc_enable), .slow_osc_crystal(slow_osc_crystal),
    .slow_osc_high_current(slow_osc_high_current),
    .slow_out_pin_gpio(slow_out_pin_gpio), .alt_pin_select(alt_pin_select),
    .slow_osc_ready(slow_osc_ready), .one_khz_out_enable(one_khz_out_enable),
    .slow_clk_out_enable(slow_clk_out_enable), .loop_enable(loop_enable),
    .loop_closed(loop_closed), .vco_coarse(vco_coarse), .vco_fine(vco_fine));
  clock_source_model i_src (
    .clk(clk), .vco_coarse(vco_coarse), .rc_tick(rc_tick),
    .ref_tick(ref_tick), .vco_tick(vco_tick));
  // ----------------------------------------
  // Monitors and timeout
  // ----------------------------------------
  // Count RC ticks the block sees between enable and ready
  always @(posedge clk) begin
    if (slow_osc_enable !== 1'b1) begin
      ticks <= 0;
    end else if (slow_osc_ready !== 1'b1 && rc_tick === 1'b1) begin
      ticks <= ticks + 1;
    end
  end
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One access: strobe for one edge, then one idle edge
  task automatic acc(input logic wr_en, input logic [9:0] a, input logic [31:0] d);
    bus_valid = 1'b1;
    bus_write = wr_en;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk);
    #1;
    bus_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    acc(1'b0, a, 32'h00000000);
    d = bus_rdata;
  endtask
  // Unlock with key and offset, then the protected write as next access
  task automatic pw(input logic [9:0] a, input logic [31:0] d);
    wr(UNLOCK_OFS, {UNLOCK_KEY, 14'h0000, a});
    wr(a, d);
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({31'h00000000, g}, {31'h00000000, e});
  endtask
  // Watch the fine output for a few reference periods
  task automatic fine_seen(output int h, output int l);
    h = 0;
    l = 0;
    repeat (1536) begin
      @(posedge clk);
      #1;
      if (vco_fine === 9'h011) h++;
      if (vco_fine === 9'h010) l++;
    end
  endtask
  task automatic pulse_reset(input logic power);
    if (power) por_n = 1'b0;
    else rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    por_n = 1'b1;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    bus_valid = 1'b0;
    bus_write = 1'b0;
    bus_addr = 10'h000;
    bus_wdata = 32'h00000000;
    bad = '{{8'h55, 14'h0000, MAIN_OSC_OFS}, {UNLOCK_KEY, 14'h0000, CONF_OFS},
      {UNLOCK_KEY, 14'h0000, MAIN_OSC_OFS}};
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    por_n = 1'b1;
    // Reset values, unmapped and unlock reads give zero
    rd(SLOW_OSC_OFS, q); cmp_word(q, SLOW_RESET);
    cmp_bit(slow_clk_out_enable, 1'b1);
    rd(MAIN_OSC_OFS, q); cmp_word(q, MAIN_RESET);
    rd(CONF_OFS, q); cmp_word(q, CONF_RESET);
    rd(MUL_OFS, q); cmp_word(q, MUL_RESET);
    rd(10'h3FC, q); cmp_word(q, 32'h00000000);
    rd(UNLOCK_OFS, q); cmp_word(q, 32'h00000000);
    // Wrong key, wrong offset, consumed unlock, no unlock: all dropped
    for (i = 0; i < 4; i++) begin
      if (i < 3) wr(UNLOCK_OFS, bad[i]);
      if (i == 2) rd(SLOW_OSC_OFS, q);
      wr(MAIN_OSC_OFS, 32'h00010001);
      rd(MAIN_OSC_OFS, q); cmp_word(q, MAIN_RESET);
    end
    // Main mode: crystal, then external clock
    pw(MAIN_OSC_OFS, 32'h00010001);
    rd(MAIN_OSC_OFS, q); cmp_word(q, 32'h00010001);
    cmp_word({29'h0, main_osc_enable, main_osc_crystal, main_out_pin_gpio}, 32'h6);
    pw(MAIN_OSC_OFS, 32'h00010000);
    cmp_word({29'h0, main_osc_enable, main_osc_crystal, main_out_pin_gpio}, 32'h5);
    // Slow oscillator modes and control bits, reserved top bit kept zero
    for (i = 0; i < 3; i++) begin
      w = {13'h0000, 3'h0, 5'h00, MODES[i], 4'h0, LOWS[i]};
      wr(SLOW_OSC_OFS, w);
      rd(SLOW_OSC_OFS, q); cmp_word(q, w);
      cmp_word({25'h0, slow_out_pin_gpio, slow_osc_crystal, slow_osc_high_current,
        one_khz_out_enable, slow_clk_out_enable, alt_pin_select, slow_osc_enable},
        {25'h0, PINS[i], LOWS[i]});
    end
    // System reset keeps the slow register, power-on reset restores it
    pulse_reset(1'b0);
    rd(SLOW_OSC_OFS, q); cmp_word(q, w);
    rd(MAIN_OSC_OFS, q); cmp_word(q, MAIN_RESET);
    pulse_reset(1'b1);
    rd(SLOW_OSC_OFS, q); cmp_word(q, SLOW_RESET);
    // Start-up wait for every code
    for (i = 0; i < 8; i++) begin
      wr(SLOW_OSC_OFS, 32'h00000000);
      cmp_bit(slow_osc_ready, 1'b0);
      wr(SLOW_OSC_OFS, {13'h0000, i[2:0], 16'h0001});
      n = 0;
      while (slow_osc_ready !== 1'b1 && n < 2000) begin
        @(posedge clk);
        #1;
        n++;
      end
      cmp_bit(slow_osc_ready, 1'b1);
      cmp_bit(ticks >= ST[i] && ticks <= ST[i] + 1, 1'b1);
    end
    // Open loop: calibration writable, multiplier ignored
    pw(CONF_OFS, 32'h20010001);
    rd(CONF_OFS, q); cmp_word(q, 32'h20010001);
    cmp_word({15'h0, vco_coarse, vco_fine}, {15'h0, 8'h20, 9'h100});
    wr(MUL_OFS, 32'h00288000);
    rd(MUL_OFS, q); cmp_word(q, MUL_RESET);
    // Closed loop, still stopped: multiplier taken before the loop starts
    pw(CONF_OFS, 32'h20010002);
    wr(MUL_OFS, 32'h00288000);
    rd(MUL_OFS, q); cmp_word(q, 32'h00288000);
    // Start the loop: calibration fields read-only, loop tunes
    pw(CONF_OFS, 32'h20010003);
    cmp_word({30'h0, loop_enable, loop_closed}, 32'h3);
    pw(CONF_OFS, 32'h55AA5503);
    rd(CONF_OFS, q);
    cmp_bit(q[31:24] >= 8'h1E && q[31:24] <= 8'h22, 1'b1);
    cmp_word({23'h0, q[16:8]}, {23'h0, 9'h100});
    repeat (7680) @(posedge clk);
    #1;
    cmp_bit(vco_coarse >= 8'h26 && vco_coarse <= 8'h2A, 1'b1);
    // Leave closed loop first; calibration fields of that write are dropped
    pw(CONF_OFS, 32'h20001001);
    // Dither on in open loop with half fraction, then off
    pw(CONF_OFS, 32'h20001005);
    cmp_bit(loop_closed, 1'b0);
    fine_seen(hi, lo);
    cmp_bit(hi > 0 && lo > 0, 1'b1);
    pw(CONF_OFS, 32'h20001001);
    fine_seen(hi, lo);
    cmp_bit(hi == 0 && lo == 1536, 1'b1);
    pw(CONF_OFS, 32'h00000000);
    cmp_bit(loop_enable, 1'b0);
    end_of_test();
  end
endmodule
